// ### rtl/pmc_cfg.svh
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH
// Register byte offsets
`define PMC_OFS_CTRL 6'h00
`define PMC_OFS_CTRLSTS 6'h04
`define PMC_OFS_IRQ_STS 6'h08
`define PMC_OFS_IRQ_MASK 6'h0C
// Control register fields
`define PMC_BIT_BACKUP_WE 8
`define PMC_BIT_THR_HI 7
`define PMC_BIT_THR_LO 5
`define PMC_BIT_MON_EN 4
`define PMC_BIT_SBY_CLR 3
`define PMC_BIT_WAKE_CLR 2
`define PMC_BIT_LP_SEL 1
`define PMC_BIT_REG_SEL 0
// Control/status register fields
`define PMC_BIT_PIN_HI_MSB 14
`define PMC_BIT_PIN_HI_LSB 11
`define PMC_BIT_PIN_LO_MSB 9
`define PMC_BIT_PIN_LO_LSB 8
`define PMC_BIT_BELOW 2
`define PMC_BIT_SBY 1
`define PMC_BIT_WAKE 0
// Interrupt status bits
`define PMC_IRQ_WAKE 0
`define PMC_IRQ_SBY 1
`define PMC_IRQ_MON_RISE 2
// Reset values and timing
`define PMC_RST_WORD 32'h0000_0000
`define PMC_RST_THR 3'h0
`define PMC_THR_UNUSED 3'h0
`define PMC_WAKE_CLR_CYCLES 2
`endif

// ### rtl/pmc_pkg.sv
package pmc_pkg;
   // Software-steered control settings
   typedef struct packed {
      logic backup_we;
      logic [2:0] thr;
      logic mon_en;
      logic lp_sel;
      logic reg_sel;
   } pmc_ctrl_t;

   // Avalon-MM request carried as one bundle
   typedef struct packed {
      logic rd;
      logic wr;
      logic [5:0] addr;
      logic [31:0] wdata;
      logic [3:0] be;
   } pmc_req_t;
endpackage : pmc_pkg

// ### rtl/pmc_regs.sv
// Chosen here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "pmc_cfg.svh"

// Overview of operation
// - Bit 8 enables writes to the battery domain; clear blocks them.
// - Bits 7:5 pick supply threshold 2.3 V to 2.9 V; code 000 unused.
// - Bit 4 enables the supply monitor; reset value zero.
// - Writing one to bit 3 clears the standby flag; reads zero.
// - Writing one to bit 2 clears wake flag two clocks later; reads zero.
// - Bit 1 picks deep sleep (0) or standby (1) on sleep request.
// - Bit 0 picks regulator normal (0) or low power (1) in deep sleep.
// - Wake pin enables at bits 14:11 and 9:8 force pull-down input.
// - Wake pin enables clear on every system reset.
// - Status bit 2 reads one while the monitor runs and supply is below threshold.
// - Supply monitor is stopped while in standby.
// - Status bit 1 set on standby entry; cleared by power reset or strobe.
// - Status bit 0 set on wake event; cleared by power reset or strobe.
// - Wake event: enabled pin rising, alarm, or enabling a high pin.
// - Supply rising above threshold while monitoring raises line 16 interrupt.
module pmc_regs (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic por_rst_n,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [5:0] wake_pin_i,
   input wire logic rtc_alarm_i,
   input wire logic supply_below_i,
   input wire logic standby_entry_i,
   input wire logic in_standby_i,
   input wire logic sleep_deep_req_i,
   output logic backup_write_enable_o,
   output logic [2:0] supply_threshold_select_o,
   output logic supply_monitor_run_o,
   output logic enter_standby_o,
   output logic enter_deep_sleep_o,
   output logic regulator_low_power_o,
   output logic [5:0] wake_pin_pulldown_o,
   output logic supply_rise_irq_o,
   output logic irq_o
);
   localparam int WAKE_CLR_CYCLES = `PMC_WAKE_CLR_CYCLES;

   pmc_pkg::pmc_req_t req;
   pmc_pkg::pmc_ctrl_t ctrl_q;
   pmc_pkg::pmc_ctrl_t ctrl_d;
   logic [7:0] sync1_q;
   logic [7:0] sync2_q;
   logic [5:0] pin_lvl_q;
   logic alarm_q;
   logic wait_q;
   logic [31:0] rdata_q;
   logic [5:0] pin_en_q;
   logic sby_flag_q;
   logic wake_flag_q;
   logic below_q;
   logic [WAKE_CLR_CYCLES-1:0] wake_clr_q;
   logic sby_clr_q;
   logic [2:0] irq_sts_q;
   logic [2:0] irq_mask_q;
   logic mon_run_q;
   logic stb_q;
   logic dsl_q;
   logic reg_lp_q;
   logic rise_q;
   logic irq_q;

   // Bus decode
   assign req = '{rd: avs_read, wr: avs_write, addr: avs_address, wdata: avs_writedata, be: avs_byteenable};
   wire acc = (req.rd | req.wr) & ~wait_q;
   wire wr_ok = acc & req.wr & (req.be == 4'hF);
   wire hit_ctrl = (req.addr == `PMC_OFS_CTRL);
   wire hit_sts = (req.addr == `PMC_OFS_CTRLSTS);
   wire hit_isr = (req.addr == `PMC_OFS_IRQ_STS);
   wire hit_msk = (req.addr == `PMC_OFS_IRQ_MASK);
   wire wr_ctrl = wr_ok & hit_ctrl;
   wire wr_sts = wr_ok & hit_sts;
   wire wr_isr = wr_ok & hit_isr;
   wire wr_msk = wr_ok & hit_msk;
   wire [2:0] wthr = req.wdata[`PMC_BIT_THR_HI:`PMC_BIT_THR_LO];

   // Synchronised pins
   wire [5:0] pin_s = sync2_q[5:0];
   wire alarm_s = sync2_q[6];
   wire below_s = sync2_q[7];

   // Event decode
   wire [5:0] pin_lvl = pin_s & pin_en_q;
   wire alarm_rise = alarm_s & ~alarm_q;
   wire wake_evt = (|(pin_lvl & ~pin_lvl_q)) | alarm_rise;
   wire mon_run = ctrl_q.mon_en & ~in_standby_i;
   wire below_d = mon_run & below_s;
   wire mon_rise = mon_run & below_q & ~below_s;
   wire [2:0] irq_evt = {mon_rise, standby_entry_i, wake_evt};

   // Control register next value
   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_ctrl) begin
         ctrl_d.backup_we = req.wdata[`PMC_BIT_BACKUP_WE];
         if (wthr != `PMC_THR_UNUSED) begin
            ctrl_d.thr = wthr;
         end
         ctrl_d.mon_en = req.wdata[`PMC_BIT_MON_EN];
         ctrl_d.lp_sel = req.wdata[`PMC_BIT_LP_SEL];
         ctrl_d.reg_sel = req.wdata[`PMC_BIT_REG_SEL];
      end
   end

   // Read data, reserved bits zero
   wire [31:0] rd_ctrl = {23'h00_0000, ctrl_q.backup_we, ctrl_q.thr, ctrl_q.mon_en, 2'b00,
                          ctrl_q.lp_sel, ctrl_q.reg_sel};
   wire [31:0] rd_sts = {17'h0_0000, pin_en_q[5:2], 1'b0, pin_en_q[1:0], 5'h00,
                         below_q, sby_flag_q, wake_flag_q};
   wire [31:0] rd_mux = hit_ctrl ? rd_ctrl :
                        hit_sts ? rd_sts :
                        hit_isr ? {29'h0000_0000, irq_sts_q} :
                        hit_msk ? {29'h0000_0000, irq_mask_q} : `PMC_RST_WORD;

   // Input synchronisers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= 8'h00;
         sync2_q <= 8'h00;
      end else begin
         sync1_q <= {supply_below_i, rtc_alarm_i, wake_pin_i};
         sync2_q <= sync1_q;
      end
   end

   // Bus slave: one wait state per access
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_q <= 1'b1;
         rdata_q <= `PMC_RST_WORD;
      end else begin
         wait_q <= ~((req.rd | req.wr) & wait_q);
         if (req.rd & wait_q) begin
            rdata_q <= rd_mux;
         end
      end
   end

   // System-reset control state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= '0;
         pin_en_q <= 6'h00;
         pin_lvl_q <= 6'h00;
         alarm_q <= 1'b0;
         below_q <= 1'b0;
         irq_sts_q <= 3'h0;
         irq_mask_q <= 3'h0;
      end else begin
         ctrl_q <= ctrl_d;
         if (wr_sts) begin
            pin_en_q <= {req.wdata[`PMC_BIT_PIN_HI_MSB:`PMC_BIT_PIN_HI_LSB],
                         req.wdata[`PMC_BIT_PIN_LO_MSB:`PMC_BIT_PIN_LO_LSB]};
         end
         pin_lvl_q <= pin_lvl;
         alarm_q <= alarm_s;
         below_q <= below_d;
         irq_sts_q <= irq_evt | (irq_sts_q & ~(wr_isr ? req.wdata[2:0] : 3'h0));
         if (wr_msk) begin
            irq_mask_q <= req.wdata[2:0];
         end
      end
   end

   // Flags survive system reset, cleared by power reset; set wins over clear
   always_ff @(posedge clk or negedge por_rst_n) begin
      if (!por_rst_n) begin
         sby_flag_q <= 1'b0;
         wake_flag_q <= 1'b0;
         sby_clr_q <= 1'b0;
         wake_clr_q <= '0;
      end else begin
         sby_clr_q <= wr_ctrl & req.wdata[`PMC_BIT_SBY_CLR];
         wake_clr_q <= {wake_clr_q[WAKE_CLR_CYCLES-2:0], wr_ctrl & req.wdata[`PMC_BIT_WAKE_CLR]};
         sby_flag_q <= standby_entry_i | (sby_flag_q & ~sby_clr_q);
         wake_flag_q <= wake_evt | (wake_flag_q & ~wake_clr_q[WAKE_CLR_CYCLES-1]);
      end
   end

   // Outputs to the power sequencer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mon_run_q <= 1'b0;
         stb_q <= 1'b0;
         dsl_q <= 1'b0;
         reg_lp_q <= 1'b0;
         rise_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         mon_run_q <= mon_run;
         stb_q <= sleep_deep_req_i & ctrl_q.lp_sel;
         dsl_q <= sleep_deep_req_i & ~ctrl_q.lp_sel;
         reg_lp_q <= sleep_deep_req_i & ~ctrl_q.lp_sel & ctrl_q.reg_sel;
         rise_q <= mon_rise;
         irq_q <= |(irq_sts_q & irq_mask_q);
      end
   end

   assign avs_readdata = rdata_q;
   assign avs_waitrequest = wait_q;
   assign backup_write_enable_o = ctrl_q.backup_we;
   assign supply_threshold_select_o = ctrl_q.thr;
   assign supply_monitor_run_o = mon_run_q;
   assign enter_standby_o = stb_q;
   assign enter_deep_sleep_o = dsl_q;
   assign regulator_low_power_o = reg_lp_q;
   assign wake_pin_pulldown_o = pin_en_q;
   assign supply_rise_irq_o = rise_q;
   assign irq_o = irq_q;

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n || !por_rst_n);

   wake_clr_two_a: assert property (wr_ctrl && req.wdata[`PMC_BIT_WAKE_CLR] && !wake_evt ##1 !wake_evt
                                    ##1 !wake_evt |=> !wake_flag_q)
      else $error("wake flag not cleared two cycles after strobe");
   wake_clr_hold_a: assert property (wr_ctrl && req.wdata[`PMC_BIT_WAKE_CLR] && wake_flag_q && !wake_evt
                                     |=> wake_flag_q)
      else $error("wake flag cleared too early");
   sby_clr_a: assert property (wr_ctrl && req.wdata[`PMC_BIT_SBY_CLR] && !standby_entry_i ##1 !standby_entry_i
                               |=> !sby_flag_q)
      else $error("standby flag not cleared by strobe");
   sby_set_a: assert property (standby_entry_i |=> sby_flag_q)
      else $error("standby flag not set on entry");
   wake_set_a: assert property (wake_evt |=> wake_flag_q && $past(wake_evt))
      else $error("wake flag not set on event");
   standby_mon_off_a: assert property (in_standby_i |=> !supply_monitor_run_o)
      else $error("monitor running in standby");
   strobe_read_zero_a: assert property (acc && req.rd && hit_ctrl |-> avs_readdata[31:9] == 23'h00_0000
                                        && avs_readdata[3:2] == 2'b00)
      else $error("reserved or strobe bits read nonzero");
   bus_one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("access not answered in one wait state");
   pin_rise_wake_a: assert property (pin_en_q[0] && $rose(pin_s[0]) && $stable(pin_en_q[0])
                                     |=> wake_flag_q)
      else $error("enabled pin rise gave no wake event");
   irq_level_a: assert property (|(irq_sts_q & irq_mask_q) |=> irq_o)
      else $error("unmasked status did not raise interrupt");
endmodule : pmc_regs

// ### tb/test_pmc_regs.sv
`timescale 1ns/1ps
module test_pmc_regs;
   logic clk, rst_n, por_rst_n, avs_read, avs_write, avs_waitrequest, rtc_alarm_i, supply_below_i;
   logic standby_entry_i, in_standby_i, sleep_deep_req_i, backup_write_enable_o, supply_monitor_run_o;
   logic enter_standby_o, enter_deep_sleep_o, regulator_low_power_o, supply_rise_irq_o, irq_o;
   logic [5:0] avs_address, wake_pin_i, wake_pin_pulldown_o;
   logic [31:0] avs_writedata, avs_readdata, x, d, ctl;
   logic [3:0] avs_byteenable;
   logic [2:0] supply_threshold_select_o;
   int err_total, total_checks, cyc, seed, i, rises;

   pmc_regs uut (.clk, .rst_n, .por_rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .wake_pin_i, .rtc_alarm_i, .supply_below_i,
      .standby_entry_i, .in_standby_i, .sleep_deep_req_i, .backup_write_enable_o,
      .supply_threshold_select_o, .supply_monitor_run_o, .enter_standby_o, .enter_deep_sleep_o,
      .regulator_low_power_o, .wake_pin_pulldown_o, .supply_rise_irq_o, .irq_o);

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic results;
      if (err_total == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : results

   // Hang guard and supply-rise pulse count
   always @(posedge clk) begin
      cyc++;
      if (supply_rise_irq_o === 1'b1) rises++;
      if (cyc == 6000) begin
         err_total++;
         results();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One Avalon-MM transfer, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] dv, input logic [3:0] b);
      @(posedge clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= dv;
      avs_byteenable <= b;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      x = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   task automatic wreg(input logic [5:0] a, input logic [31:0] dv);
      bus(1'b1, a, dv, 4'hF);
   endtask : wreg

   task automatic rc(input logic [5:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000, 4'hF);
      chk(x, e);
   endtask : rc

   task automatic cy(input int n);
      repeat (n) @(posedge clk);
   endtask : cy

   // Control readback: strobes and reserved bits read zero, threshold 000 keeps old code
   function automatic logic [31:0] cexp(input logic [31:0] o, input logic [31:0] n);
      cexp = n & 32'h0000_01F3;
      if (n[7:5] == 3'h0) cexp[7:5] = o[7:5];
   endfunction : cexp

   initial begin
      seed = 32'h0156;
      {rst_n, por_rst_n, avs_read, avs_write, rtc_alarm_i, supply_below_i} = 6'h00;
      {standby_entry_i, in_standby_i, sleep_deep_req_i} = 3'h0;
      avs_address = 6'h00;
      wake_pin_i = 6'h00;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'hF;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      por_rst_n <= 1'b1;
      rc(6'h00, 32'h0000_0000);
      rc(6'h04, 32'h0000_0000);
      rc(6'h10, 32'h0000_0000);
      ctl = 32'h0000_0000;
      for (i = 0; i < 8; i++) begin
         d = $random(seed) & 32'h0000_01FF;
         d[7:5] = 3'(7 - i);
         wreg(6'h00, d);
         ctl = cexp(ctl, d);
         rc(6'h00, ctl);
         chk({23'h0, backup_write_enable_o, supply_threshold_select_o, 5'h00}, ctl & 32'h0000_01E0);
      end
      bus(1'b1, 6'h00, ~ctl & 32'h0000_01FF, 4'h3);
      rc(6'h00, ctl);
      for (i = 0; i < 4; i++) begin
         d = $random(seed) & 32'h0000_7B00;
         wreg(6'h04, d);
         rc(6'h04, d & 32'h0000_7B00);
         chk({26'h0, wake_pin_pulldown_o}, {26'h0, d[14:11], d[9:8]});
      end
      wreg(6'h04, 32'h0000_0000);
      sleep_deep_req_i <= 1'b1;
      for (i = 0; i < 4; i++) begin
         wreg(6'h00, {30'h0, i[1:0]});
         cy(2);
         chk({29'h0, enter_standby_o, enter_deep_sleep_o, regulator_low_power_o},
            {29'h0, i[1], !i[1], !i[1] & i[0]});
      end
      sleep_deep_req_i <= 1'b0;
      wreg(6'h00, 32'h0000_0030);
      supply_below_i <= 1'b1;
      cy(4);
      rc(6'h04, 32'h0000_0004);
      chk({31'h0, supply_monitor_run_o}, 32'h0000_0001);
      in_standby_i <= 1'b1;
      cy(3);
      rc(6'h04, 32'h0000_0000);
      chk({31'h0, supply_monitor_run_o}, 32'h0000_0000);
      in_standby_i <= 1'b0;
      wreg(6'h0C, 32'h0000_0004);
      cy(3);
      supply_below_i <= 1'b0;
      cy(5);
      rc(6'h08, 32'h0000_0004);
      chk({31'h0, irq_o}, 32'h0000_0001);
      chk(rises, 32'h0000_0001);
      wreg(6'h08, 32'h0000_0004);
      cy(2);
      chk({31'h0, irq_o}, 32'h0000_0000);
      sleep_deep_req_i <= 1'b1;
      wreg(6'h00, 32'h0000_0006);
      cy(2);
      chk({31'h0, enter_standby_o}, 32'h0000_0001);
      standby_entry_i <= 1'b1;
      @(posedge clk);
      standby_entry_i <= 1'b0;
      sleep_deep_req_i <= 1'b0;
      rtc_alarm_i <= 1'b1;
      cy(4);
      rc(6'h04, 32'h0000_0003);
      rc(6'h08, 32'h0000_0003);
      rtc_alarm_i <= 1'b0;
      wreg(6'h00, 32'h0000_0008);
      cy(3);
      rc(6'h04, 32'h0000_0001);
      wreg(6'h00, 32'h0000_0004);
      cy(4);
      rc(6'h04, 32'h0000_0000);
      wreg(6'h04, 32'h0000_0300);
      cy(4);
      rc(6'h04, 32'h0000_0300);
      wake_pin_i <= 6'h02;
      cy(5);
      rc(6'h04, 32'h0000_0301);
      wreg(6'h00, 32'h0000_0004);
      cy(4);
      rc(6'h04, 32'h0000_0300);
      wake_pin_i <= 6'h22;
      cy(4);
      wreg(6'h04, 32'h0000_4300);
      cy(4);
      rc(6'h04, 32'h0000_4301);
      rst_n <= 1'b0;
      cy(2);
      rst_n <= 1'b1;
      rc(6'h04, 32'h0000_0001);
      chk({26'h0, wake_pin_pulldown_o}, 32'h0000_0000);
      por_rst_n <= 1'b0;
      cy(2);
      por_rst_n <= 1'b1;
      rc(6'h04, 32'h0000_0000);
      results();
   end
endmodule : test_pmc_regs
